// ===== hw/cpc_pkg.sv
package cpc_pkg;
    localparam int          CPC_MAX_DEG       = 32;
    localparam int          CPC_LEN_W         = 5;
    localparam int          CPC_HALF_W        = 16;
    localparam logic [4:0]  CPC_LEN_LSB       = 5'h00;
    localparam logic [15:0] CPC_CTL2_RST      = 16'h0000;
    localparam logic [15:0] CPC_TERM_LOW_RST  = 16'h0000;
    localparam logic [15:0] CPC_TERM_HIGH_RST = 16'h0000;
    localparam int          CPC_TERM_LOW_IMPL = 0;
    localparam logic [15:0] CPC_LOW_MASK      = 16'hFFFE;
    localparam logic [15:0] CPC_CTL2_MASK     = 16'h001F;
    localparam logic [5:0]  CPC_DEG_OFS       = 6'h01;
    localparam logic [5:0]  CPC_DEG_RST       = 6'h01;
    localparam logic [31:0] CPC_TAPS_RST      = 32'h00000001;
    localparam logic [31:0] CPC_TOP_RST       = 32'h00000001;
    localparam int          CPC_CONST_TAP     = 0;
endpackage

// ===== hw/cpc_cfg_if.sv
`timescale 1ns/100ps
interface cpc_cfg_if;
    logic [4:0]  len_field;
    logic [31:0] term_en;
    logic [31:0] tap_mask;
    logic [31:0] top_onehot;
    modport src (output len_field, output term_en, input tap_mask, input top_onehot);
    modport dec (input len_field, input term_en, output tap_mask, output top_onehot);
endinterface

// ===== hw/cpc_tap_dec.sv
`timescale 1ns/100ps
module cpc_tap_dec
    import cpc_pkg::*;
(
    cpc_cfg_if.dec cfg
);
    function automatic logic [31:0] cpc_onehot(input logic [4:0] idx);
        cpc_onehot = 32'h00000001 << idx;
    endfunction

    // bit k of tap_mask means "xor feedback into engine bit k"; bit 0 is the
    // constant term which must always be applied. the degree term has no enable:
    // it is the shift-out of the top engine bit, flagged in top_onehot instead
    always_comb begin
        cfg.top_onehot  = cpc_onehot(cfg.len_field);
        cfg.tap_mask    = cfg.term_en;
        cfg.tap_mask[0] = 1'b1;
    end
endmodule // cpc_tap_dec

// ===== hw/cpc_poly_cfg.sv
`timescale 1ns/100ps
// Overview of operation
// - degree up to 32, 32 feedback positions
// - five-bit length field sets polynomial degree
// - set enable bit adds feedback xor
// - constant term always xored in feedback
// - degree term always present regardless of enables
// - no enable storage for exponent 32
// - high register holds exponents 31..16
// - low register bits 15..1, bit0 reads zero
module cpc_poly_cfg
    import cpc_pkg::*;
#(
    parameter int DEG_MAX = CPC_MAX_DEG
) (
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic        ce_in,
    input  wire logic        ctl2_we_in,
    input  wire logic        low_we_in,
    input  wire logic        high_we_in,
    input  wire logic [15:0] wdata_in,
    output logic      [15:0] crc_control_two_out,
    output logic      [15:0] poly_term_enable_low_out,
    output logic      [15:0] poly_term_enable_high_out,
    output logic      [5:0]  poly_degree_out,
    output logic      [31:0] feedback_taps_out,
    output logic      [31:0] top_term_out
);
    logic [4:0]  poly_length_field_r;
    logic [15:0] term_low_r;
    logic [15:0] term_high_r;
    cpc_cfg_if   cfg ();

    // degree is one above the stored field so that five bits reach degree 32
    function automatic logic [5:0] cpc_degree(input logic [CPC_LEN_W-1:0] len);
        cpc_degree = {1'b0, len} + CPC_DEG_OFS;
    endfunction

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            poly_length_field_r <= CPC_CTL2_RST[CPC_LEN_W-1:0];
        end else if (ce_in && ctl2_we_in) begin
            poly_length_field_r <= wdata_in[CPC_LEN_W-1:0];
        end
    end

    len_write_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && ctl2_we_in |=> poly_length_field_r == $past(wdata_in[CPC_LEN_W-1:0]))
        else $error("length field write lost");
    len_freeze_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !ce_in |=> $stable(poly_length_field_r))
        else $error("length field moved without enable");

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            term_low_r <= CPC_TERM_LOW_RST;
        end else if (ce_in && low_we_in) begin
            term_low_r <= wdata_in & CPC_LOW_MASK;
        end
    end

    low_store_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && low_we_in |=> term_low_r == ($past(wdata_in) & CPC_LOW_MASK))
        else $error("low enable write lost");
    low_freeze_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !ce_in |=> $stable(term_low_r))
        else $error("low enables moved without enable");

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            term_high_r <= CPC_TERM_HIGH_RST;
        end else if (ce_in && high_we_in) begin
            term_high_r <= wdata_in;
        end
    end

    high_store_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && high_we_in |=> term_high_r == $past(wdata_in))
        else $error("high enable write lost");
    high_freeze_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !ce_in |=> $stable(term_high_r))
        else $error("high enables moved without enable");

    // only 32 stored enables: exponent 32 has no bit, it comes from top_onehot
    assign cfg.len_field = poly_length_field_r;
    assign cfg.term_en   = {term_high_r, term_low_r};

    cpc_tap_dec u_dec (
        .cfg (cfg)
    );

    // outputs registered so the engine sees taps one cycle after a write;
    // one process per output keeps every freeze and reset path separate
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            crc_control_two_out <= CPC_CTL2_RST;
        end else if (ce_in) begin
            crc_control_two_out <= {11'h000, poly_length_field_r} & CPC_CTL2_MASK;
        end
    end

    ctl2_follow_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && ctl2_we_in ##1 ce_in |=> crc_control_two_out == {11'h000, $past(wdata_in[CPC_LEN_W-1:0], 2)})
        else $error("length field readback wrong");
    ctl2_upper_zero_a: assert property (@(posedge clk_in) disable iff (srst_in)
        (crc_control_two_out & ~CPC_CTL2_MASK) == 16'h0000)
        else $error("control two upper bits set");
    ctl2_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !ce_in |=> $stable(crc_control_two_out))
        else $error("control two moved without enable");

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            poly_term_enable_low_out <= CPC_TERM_LOW_RST;
        end else if (ce_in) begin
            poly_term_enable_low_out <= term_low_r & CPC_LOW_MASK;
        end
    end

    low_bit0_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !poly_term_enable_low_out[CPC_TERM_LOW_IMPL])
        else $error("low bit0 set");
    low_write_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && low_we_in ##1 ce_in |=> poly_term_enable_low_out == ($past(wdata_in, 2) & CPC_LOW_MASK))
        else $error("low write lost");
    low_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !ce_in |=> $stable(poly_term_enable_low_out))
        else $error("low enables output moved without enable");

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            poly_term_enable_high_out <= CPC_TERM_HIGH_RST;
        end else if (ce_in) begin
            poly_term_enable_high_out <= term_high_r;
        end
    end

    high_write_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && high_we_in ##1 ce_in |=> poly_term_enable_high_out == $past(wdata_in, 2))
        else $error("high write lost");
    high_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !ce_in |=> $stable(poly_term_enable_high_out))
        else $error("high enables output moved without enable");

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            poly_degree_out <= CPC_DEG_RST;
        end else if (ce_in) begin
            poly_degree_out <= cpc_degree(poly_length_field_r);
        end
    end

    degree_map_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && ctl2_we_in ##1 ce_in |=> poly_degree_out == {1'b0, $past(wdata_in[CPC_LEN_W-1:0], 2)} + CPC_DEG_OFS)
        else $error("degree not length plus one");
    degree_range_a: assert property (@(posedge clk_in) disable iff (srst_in)
        poly_degree_out >= CPC_DEG_OFS && poly_degree_out <= 6'(DEG_MAX))
        else $error("degree out of range");
    degree_ctl2_a: assert property (@(posedge clk_in) disable iff (srst_in)
        poly_degree_out == cpc_degree(crc_control_two_out[CPC_LEN_W-1:0]))
        else $error("degree disagrees with length field");
    degree_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !ce_in |=> $stable(poly_degree_out))
        else $error("degree moved without enable");

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            feedback_taps_out <= CPC_TAPS_RST;
        end else if (ce_in) begin
            feedback_taps_out <= cfg.tap_mask;
        end
    end

    taps_const_a: assert property (@(posedge clk_in) disable iff (srst_in)
        feedback_taps_out[CPC_CONST_TAP])
        else $error("constant term missing");
    tap_follow_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && low_we_in ##1 ce_in |=> feedback_taps_out[15:1] == $past(wdata_in[15:1], 2))
        else $error("low taps wrong");
    tap_high_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && high_we_in ##1 ce_in |=> feedback_taps_out[31:16] == $past(wdata_in, 2))
        else $error("high taps wrong");
    taps_mirror_a: assert property (@(posedge clk_in) disable iff (srst_in)
        feedback_taps_out[31:1] == {poly_term_enable_high_out, poly_term_enable_low_out[15:1]})
        else $error("taps differ from stored enables");
    state_freeze_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !ce_in |=> $stable(feedback_taps_out))
        else $error("taps moved without enable");

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            top_term_out <= CPC_TOP_RST;
        end else if (ce_in) begin
            top_term_out <= cfg.top_onehot;
        end
    end

    top_match_a: assert property (@(posedge clk_in) disable iff (srst_in)
        top_term_out == (32'h00000001 << (poly_degree_out[4:0] - 5'h01)))
        else $error("top term wrong");
    top_onehot_a: assert property (@(posedge clk_in) disable iff (srst_in)
        $onehot(top_term_out))
        else $error("top term not a single bit");
    top_len_a: assert property (@(posedge clk_in) disable iff (srst_in)
        top_term_out == (32'h00000001 << crc_control_two_out[CPC_LEN_W-1:0]))
        else $error("top term disagrees with length field");
    top_full_a: assert property (@(posedge clk_in) disable iff (srst_in)
        poly_degree_out == 6'(DEG_MAX) |-> top_term_out[DEG_MAX-1])
        else $error("full degree top term missing");
    top_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !ce_in |=> $stable(top_term_out))
        else $error("top term moved without enable");

    // reset wins over a low clock enable, so these hold after any reset cycle
    rst_regs_a: assert property (@(posedge clk_in)
        $past(srst_in) |->
        poly_term_enable_high_out == CPC_TERM_HIGH_RST && poly_term_enable_low_out == CPC_TERM_LOW_RST)
        else $error("enable outputs not cleared by reset");
    rst_outputs_a: assert property (@(posedge clk_in)
        $past(srst_in) |->
        poly_degree_out == CPC_DEG_RST && feedback_taps_out == CPC_TAPS_RST && top_term_out == CPC_TOP_RST)
        else $error("degree or taps not reset");
endmodule // cpc_poly_cfg

// ===== bench/cpc_poly_cfg_tb_top.sv
`timescale 1ns/100ps
module cpc_poly_cfg_tb_top;
    import cpc_pkg::*;
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        ce_in = 1'b0;
    logic        ctl2_we_in = 1'b0;
    logic        low_we_in = 1'b0;
    logic        high_we_in = 1'b0;
    logic [15:0] wdata_in = 16'h0000;
    logic [15:0] ctl2_o, low_o, high_o;
    logic [5:0]  deg_o;
    logic [31:0] taps_o, top_o, seed, r, en_m;
    int          miscompares = 0, n_tests = 0, cycles = 0, len_m = 0;
    cpc_poly_cfg dut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in), .ctl2_we_in(ctl2_we_in),
        .low_we_in(low_we_in), .high_we_in(high_we_in), .wdata_in(wdata_in), .crc_control_two_out(ctl2_o),
        .poly_term_enable_low_out(low_o), .poly_term_enable_high_out(high_o), .poly_degree_out(deg_o),
        .feedback_taps_out(taps_o), .top_term_out(top_o));
    always #4 clk_in = ~clk_in;
    task automatic stop_test();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // 200 writes of 3 cycles each fit well inside this ceiling
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            stop_test();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_all();
        chk({16'h0000, ctl2_o}, {27'h0, len_m[4:0]});
        chk({26'h0, deg_o}, len_m + 1);
        chk({16'h0000, low_o}, {16'h0000, en_m[15:0]});
        chk({16'h0000, high_o}, {16'h0000, en_m[31:16]});
        chk(taps_o, en_m | 32'h1);
        chk(top_o, 32'h1 << len_m);
    endtask
    initial begin
        seed = 32'd36;
        en_m = 32'h0;
        repeat (6) @(posedge clk_in);
        srst_in <= 1'b0;
        @(negedge clk_in);
        check_all();
        $display("reset values test done");
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_in);
            r = xs();
            ce_in      <= r[0] | r[1];
            ctl2_we_in <= r[2];
            low_we_in  <= r[3];
            high_we_in <= r[4];
            wdata_in   <= r[31:16];
            // a strobe with clock enable low must leave the model untouched
            if (r[0] | r[1]) begin
                if (r[2]) len_m = int'(r[20:16]);
                if (r[3]) en_m[15:0] = r[31:16] & 16'hFFFE;
                if (r[4]) en_m[31:16] = r[31:16];
            end
            @(posedge clk_in);
            ce_in      <= 1'b1;
            ctl2_we_in <= 1'b0;
            low_we_in  <= 1'b0;
            high_we_in <= 1'b0;
            // the strobe landed on the edge above, the outputs follow on the next
            @(posedge clk_in);
            @(negedge clk_in);
            check_all();
        end
        $display("random write test done");
        stop_test();
    end
endmodule // cpc_poly_cfg_tb_top
